// *** rtl/sdc_pkg.sv ***
// Shared constants and types for the six-channel DMA controller
package sdc_pkg;

  localparam int NUM_CH      = 6;
  localparam int CH_W        = 3;
  localparam int XFER_CYCLES = 5;

  // Per-channel register block: channel n sits at n * CH_STRIDE
  localparam logic [11:0] CH_STRIDE = 12'h040;
  localparam logic [5:0]  OFF_SRC   = 6'h00;
  localparam logic [5:0]  OFF_DST   = 6'h04;
  localparam logic [5:0]  OFF_ECNT  = 6'h08;
  localparam logic [5:0]  OFF_FCNT  = 6'h0c;
  localparam logic [5:0]  OFF_MODE  = 6'h10;
  localparam logic [5:0]  OFF_RSRC  = 6'h14;
  localparam logic [5:0]  OFF_RDST  = 6'h18;
  localparam logic [5:0]  OFF_RECNT = 6'h1c;
  localparam logic [5:0]  OFF_RFCNT = 6'h20;

  // Global registers
  localparam logic [11:0] GLB_BASE  = 12'h180;
  localparam logic [11:0] ADR_GSRC  = 12'h180;
  localparam logic [11:0] ADR_GDST  = 12'h184;
  localparam logic [11:0] ADR_GECNT = 12'h188;
  localparam logic [11:0] ADR_GFCNT = 12'h18c;
  localparam logic [11:0] ADR_EIDXA = 12'h190;
  localparam logic [11:0] ADR_EIDXB = 12'h194;
  localparam logic [11:0] ADR_FIDXA = 12'h198;
  localparam logic [11:0] ADR_FIDXB = 12'h19c;
  localparam logic [11:0] ADR_CFG   = 12'h1a0;
  localparam logic [11:0] ADR_STAT  = 12'h1a4;

  // Mode register fields
  localparam int M_EN   = 0;
  localparam int M_HIPR = 1;
  localparam int M_SYNC = 2;
  localparam int M_ESEL = 3;
  localparam int M_SMOD = 6;
  localparam int M_SSEL = 8;
  localparam int M_DMOD = 9;
  localparam int M_DSEL = 11;
  localparam int M_DBL  = 12;
  localparam int M_AUTO = 13;
  localparam int M_INTE = 14;
  localparam int M_INTERRUPT_MODE_SELECT = 15;
  localparam int CFG_PERCH = 0;

  localparam logic [15:0] RST_W16 = 16'h0000;
  localparam logic [7:0]  RST_W8  = 8'h00;

  typedef enum logic [1:0] {
    ADJ_HOLD = 2'b00,
    ADJ_INC  = 2'b01,
    ADJ_DEC  = 2'b10,
    ADJ_IDX  = 2'b11
  } sdc_adj_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD   = 3'b001,
    S_RDW  = 3'b010,
    S_WR   = 3'b011,
    S_WRW  = 3'b100,
    S_UPD  = 3'b101
  } sdc_fsm_type;

endpackage

// *** rtl/sdc_rr_pick.sv ***
// Round-robin picker: first request at or after the start index wins
`timescale 1ns/1ps
module sdc_rr_pick #(
  parameter int N = 6,
  parameter int W = 3
) (
  input  wire logic [N-1:0] req_in,    // Pending requests
  input  wire logic [W-1:0] start_in,  // Highest-preference index
  output logic      [W-1:0] grant_out, // Chosen index
  output logic              valid_out  // Any request present
);
  int idx;

  always_comb begin
    grant_out = '0;
    valid_out = 1'b0;
    idx       = 0;
    // Scan downward so the index nearest the start is assigned last
    for (int k = N - 1; k >= 0; k--) begin
      idx = (int'(start_in) + k) % N;
      if (req_in[idx]) begin
        grant_out = W'(idx);
        valid_out = 1'b1;
      end
    end
  end
endmodule

// *** rtl/sdc_dma.sv ***
// Six-channel DMA controller with AHB-Lite register slave
`timescale 1ns/1ps
module sdc_dma
  import sdc_pkg::*;
#(
  parameter int NUM_EVT = 8
) (
  input  wire logic               clk_in,                 // 10 MHz clock
  input  wire logic               srst_in,                // Sync reset, high
  input  wire logic               hsel_in,                // AHB select
  input  wire logic [31:0]        haddr_in,               // AHB address
  input  wire logic [1:0]         htrans_in,              // AHB transfer type
  input  wire logic               hwrite_in,              // AHB write
  input  wire logic [2:0]         hsize_in,               // AHB size, word only
  input  wire logic [31:0]        hwdata_in,              // AHB write data
  input  wire logic               hready_in,              // AHB bus ready
  output logic                    hreadyout_out,          // AHB slave ready
  output logic                    hresp_out,              // AHB response
  output logic      [31:0]        hrdata_out,             // AHB read data
  input  wire logic [NUM_EVT-1:0] sync_events_in,         // Sync event strobes
  input  wire logic               cpu_req_in,             // Core wants memory bus
  output logic                    cpu_grant_out,          // Core may use bus
  output logic                    mem_busy_out,           // DMA owns bus
  output logic                    mem_rd_out,             // Memory read strobe
  output logic                    mem_wr_out,             // Memory write strobe
  output logic      [15:0]        mem_addr_out,           // Memory word address
  output logic      [15:0]        mem_wdata_out,          // Memory write data
  input  wire logic [15:0]        mem_rdata_in,           // Memory read data
  input  wire logic               microcomputer_mode_bit, // Core config, unused
  input  wire logic               data_rom_map_bit,       // Core config, unused
  input  wire logic               ram_overlay_bit,        // Core config, unused
  output logic      [NUM_CH-1:0]  dma_int_out             // Channel interrupt pulses
);

  // every channel keeps its own address, count, mode and reload registers; index and global reload registers are shared
  typedef struct packed {
    logic [NUM_CH-1:0][15:0] src;
    logic [NUM_CH-1:0][15:0] dst;
    logic [NUM_CH-1:0][15:0] ecnt;
    logic [NUM_CH-1:0][7:0]  fcnt;
    logic [NUM_CH-1:0][15:0] mode;
    logic [NUM_CH-1:0][15:0] rsrc;
    logic [NUM_CH-1:0][15:0] rdst;
    logic [NUM_CH-1:0][15:0] recnt;
    logic [NUM_CH-1:0][7:0]  rfcnt;
    logic [15:0]             global_source_reload;
    logic [15:0]             global_destination_reload;
    logic [15:0]             global_element_count_reload;
    logic [7:0]              global_frame_count_reload;
    logic [15:0]             element_index_a;
    logic [15:0]             element_index_b;
    logic [15:0]             frame_index_a;
    logic [15:0]             frame_index_b;
    logic                    per_ch_reload;
    logic [NUM_CH-1:0]       evt_pend;
    logic [NUM_CH-1:0]       irq;
    sdc_fsm_type             st;
    logic [CH_W-1:0]         ch;
    logic                    dhalf;
    logic [15:0]             data;
    logic [CH_W-1:0]         hi_ptr;
    logic [CH_W-1:0]         lo_ptr;
    logic                    wr_pend;
    logic [11:0]             waddr;
    logic [31:0]             rdata;
  } sdc_state_type;

  sdc_state_type     state_r;
  sdc_state_type     state_nxt;
  logic [NUM_CH-1:0] ready;
  logic [NUM_CH-1:0] hi_req;
  logic [NUM_CH-1:0] lo_req;
  logic [CH_W-1:0]   hi_idx;
  logic [CH_W-1:0]   lo_idx;
  logic              hi_val;
  logic              lo_val;
  logic [CH_W-1:0]   gnt;
  logic              gnt_val;
  logic              acc;
  logic [15:0]       md;
  logic              last_half;
  logic              eof;
  logic              half_pt;
  logic [CH_W-1:0]   wc;
  logic [5:0]        wo;

  function automatic logic is_ch(input logic [11:0] a);
    return (a < GLB_BASE) && (a[8:6] < CH_W'(NUM_CH));
  endfunction

  function automatic logic [15:0] adj(input logic [15:0] a, input logic [1:0] m,
                                      input logic sel, input logic last,
                                      input sdc_state_type s);
    case (sdc_adj_type'(m))
      ADJ_HOLD: return a;
      ADJ_INC:  return a + 16'h0001;
      ADJ_DEC:  return a - 16'h0001;
      default:  return last ? a + (sel ? s.frame_index_b : s.frame_index_a)
                            : a + (sel ? s.element_index_b : s.element_index_a);
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input sdc_state_type s, input logic [11:0] a);
    logic [CH_W-1:0] c;
    logic [5:0]      o;
    c = a[8:6];
    o = a[5:0];
    if (is_ch(a)) begin
      if (o == OFF_SRC) return {16'h0000, s.src[c]};
      else if (o == OFF_DST) return {16'h0000, s.dst[c]};
      else if (o == OFF_ECNT) return {16'h0000, s.ecnt[c]};
      else if (o == OFF_FCNT) return {24'h000000, s.fcnt[c]};
      else if (o == OFF_MODE) return {16'h0000, s.mode[c]};
      else if (o == OFF_RSRC) return {16'h0000, s.rsrc[c]};
      else if (o == OFF_RDST) return {16'h0000, s.rdst[c]};
      else if (o == OFF_RECNT) return {16'h0000, s.recnt[c]};
      else if (o == OFF_RFCNT) return {24'h000000, s.rfcnt[c]};
      else return 32'h00000000;
    end
    else if (a == ADR_GSRC) return {16'h0000, s.global_source_reload};
    else if (a == ADR_GDST) return {16'h0000, s.global_destination_reload};
    else if (a == ADR_GECNT) return {16'h0000, s.global_element_count_reload};
    else if (a == ADR_GFCNT) return {24'h000000, s.global_frame_count_reload};
    else if (a == ADR_EIDXA) return {16'h0000, s.element_index_a};
    else if (a == ADR_EIDXB) return {16'h0000, s.element_index_b};
    else if (a == ADR_FIDXA) return {16'h0000, s.frame_index_a};
    else if (a == ADR_FIDXB) return {16'h0000, s.frame_index_b};
    else if (a == ADR_CFG) return {31'h00000000, s.per_ch_reload};
    else if (a == ADR_STAT) return {21'h000000, s.ch, 1'b0, (s.st != S_IDLE), s.evt_pend};
    else return 32'h00000000;
  endfunction

  // channel ready when enabled and, if synced, event seen
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_rdy
      assign ready[gc]  = state_r.mode[gc][M_EN] &&
                          (!state_r.mode[gc][M_SYNC] || state_r.evt_pend[gc]);
      assign hi_req[gc] = ready[gc] && state_r.mode[gc][M_HIPR];
      assign lo_req[gc] = ready[gc] && !state_r.mode[gc][M_HIPR];
    end
  endgenerate

  sdc_rr_pick #(.N(NUM_CH), .W(CH_W)) u_pick_hi (
    .req_in    (hi_req),
    .start_in  (state_r.hi_ptr),
    .grant_out (hi_idx),
    .valid_out (hi_val)
  );

  sdc_rr_pick #(.N(NUM_CH), .W(CH_W)) u_pick_lo (
    .req_in    (lo_req),
    .start_in  (state_r.lo_ptr),
    .grant_out (lo_idx),
    .valid_out (lo_val)
  );

  assign gnt     = hi_val ? hi_idx : lo_idx;
  assign gnt_val = hi_val || lo_val;
  assign acc     = hsel_in && htrans_in[1] && hready_in;
  assign md      = state_r.mode[state_r.ch];
  assign wc      = state_r.waddr[8:6];
  assign wo      = state_r.waddr[5:0];

  always_comb begin
    state_nxt = state_r;
    state_nxt.irq = '0;
    last_half = !md[M_DBL] || state_r.dhalf;
    eof       = last_half && (state_r.ecnt[state_r.ch] == RST_W16);
    // half point rounds up so an even block splits in two equal parts
    half_pt   = last_half && (state_r.fcnt[state_r.ch] == RST_W8) &&
                (state_r.ecnt[state_r.ch] == {1'b0, state_r.recnt[state_r.ch][15:1]} +
                                             16'(state_r.recnt[state_r.ch][0]));
    // RD, RDW, WR, WRW, UPD: five cycles per transfer
    case (state_r.st)
      S_IDLE: begin
        if (state_r.dhalf) begin
          // second half keeps the channel; no arbitration in between
          state_nxt.st    = md[M_EN] ? S_RD : S_IDLE;
          state_nxt.dhalf = md[M_EN];
        end
        else if (gnt_val) begin
          state_nxt.ch = gnt;
          state_nxt.st = S_RD;
          state_nxt.evt_pend[gnt] = 1'b0;
          // pointer moves past the serviced channel
          if (hi_val) begin
            state_nxt.hi_ptr = (gnt == CH_W'(NUM_CH - 1)) ? '0 : gnt + CH_W'(1);
          end
          else begin
            state_nxt.lo_ptr = (gnt == CH_W'(NUM_CH - 1)) ? '0 : gnt + CH_W'(1);
          end
        end
      end
      S_RD: begin
        state_nxt.st = S_RDW;
      end
      S_RDW: begin
        state_nxt.data = mem_rdata_in;
        state_nxt.st   = S_WR;
      end
      S_WR: begin
        state_nxt.st = S_WRW;
      end
      S_WRW: begin
        state_nxt.st = S_UPD;
      end
      S_UPD: begin
        state_nxt.st = S_IDLE;
        state_nxt.src[state_r.ch] = adj(state_r.src[state_r.ch], md[M_SMOD +: 2],
                                        md[M_SSEL], eof, state_r);
        state_nxt.dst[state_r.ch] = adj(state_r.dst[state_r.ch], md[M_DMOD +: 2],
                                        md[M_DSEL], eof, state_r);
        if (!last_half) begin
          // second half of a double word follows
          state_nxt.dhalf = 1'b1;
        end
        else begin
          state_nxt.dhalf = 1'b0;
          if (!eof) begin
            state_nxt.ecnt[state_r.ch] = state_r.ecnt[state_r.ch] - 16'h0001;
            if (half_pt && md[M_INTE] && md[M_INTERRUPT_MODE_SELECT]) begin
              state_nxt.irq[state_r.ch] = 1'b1;
            end
          end
          else if (state_r.fcnt[state_r.ch] != RST_W8) begin
            // frame end, refill element count for next frame
            state_nxt.fcnt[state_r.ch] = state_r.fcnt[state_r.ch] - 8'h01;
            state_nxt.ecnt[state_r.ch] = state_r.per_ch_reload ?
                                         state_r.recnt[state_r.ch] :
                                         state_r.global_element_count_reload;
            // frame interrupt only in mode one
            if (md[M_INTE] && md[M_INTERRUPT_MODE_SELECT]) begin
              state_nxt.irq[state_r.ch] = 1'b1;
            end
          end
          else begin
            state_nxt.irq[state_r.ch] = md[M_INTE];
            if (md[M_AUTO]) begin
              if (state_r.per_ch_reload) begin
                state_nxt.src[state_r.ch]  = state_r.rsrc[state_r.ch];
                state_nxt.dst[state_r.ch]  = state_r.rdst[state_r.ch];
                state_nxt.ecnt[state_r.ch] = state_r.recnt[state_r.ch];
                state_nxt.fcnt[state_r.ch] = state_r.rfcnt[state_r.ch];
              end
              else begin
                state_nxt.src[state_r.ch]  = state_r.global_source_reload;
                state_nxt.dst[state_r.ch]  = state_r.global_destination_reload;
                state_nxt.ecnt[state_r.ch] = state_r.global_element_count_reload;
                state_nxt.fcnt[state_r.ch] = state_r.global_frame_count_reload;
              end
            end
            else begin
              // stop, keep final address and count
              state_nxt.mode[state_r.ch][M_EN] = 1'b0;
            end
          end
        end
      end
      default: begin
        state_nxt.st = S_IDLE;
      end
    endcase
    // Software write in data phase; lands after the engine so it overrides
    if (state_r.wr_pend) begin
      if (is_ch(state_r.waddr)) begin
        if (wo == OFF_SRC) state_nxt.src[wc] = hwdata_in[15:0];
        else if (wo == OFF_DST) state_nxt.dst[wc] = hwdata_in[15:0];
        else if (wo == OFF_ECNT) state_nxt.ecnt[wc] = hwdata_in[15:0];
        else if (wo == OFF_FCNT) state_nxt.fcnt[wc] = hwdata_in[7:0];
        else if (wo == OFF_MODE) state_nxt.mode[wc] = hwdata_in[15:0];
        else if (wo == OFF_RSRC) state_nxt.rsrc[wc] = hwdata_in[15:0];
        else if (wo == OFF_RDST) state_nxt.rdst[wc] = hwdata_in[15:0];
        else if (wo == OFF_RECNT) state_nxt.recnt[wc] = hwdata_in[15:0];
        else if (wo == OFF_RFCNT) state_nxt.rfcnt[wc] = hwdata_in[7:0];
      end
      else if (state_r.waddr == ADR_GSRC) state_nxt.global_source_reload = hwdata_in[15:0];
      else if (state_r.waddr == ADR_GDST) state_nxt.global_destination_reload = hwdata_in[15:0];
      else if (state_r.waddr == ADR_GECNT) state_nxt.global_element_count_reload = hwdata_in[15:0];
      else if (state_r.waddr == ADR_GFCNT) state_nxt.global_frame_count_reload = hwdata_in[7:0];
      else if (state_r.waddr == ADR_EIDXA) state_nxt.element_index_a = hwdata_in[15:0];
      else if (state_r.waddr == ADR_EIDXB) state_nxt.element_index_b = hwdata_in[15:0];
      else if (state_r.waddr == ADR_FIDXA) state_nxt.frame_index_a = hwdata_in[15:0];
      else if (state_r.waddr == ADR_FIDXB) state_nxt.frame_index_b = hwdata_in[15:0];
      else if (state_r.waddr == ADR_CFG) state_nxt.per_ch_reload = hwdata_in[CFG_PERCH];
    end
    // event capture; set wins over the clear at transfer start
    for (int c = 0; c < NUM_CH; c++) begin
      if (state_r.mode[c][M_SYNC] && sync_events_in[state_r.mode[c][M_ESEL +: 3]]) begin
        state_nxt.evt_pend[c] = 1'b1;
      end
    end
    state_nxt.wr_pend = acc && hwrite_in;
    state_nxt.waddr   = haddr_in[11:0];
    if (acc && !hwrite_in) begin
      state_nxt.rdata = rd_word(state_r, haddr_in[11:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r       <= '0;
      state_r.st    <= S_IDLE;
    end
    else begin
      state_r <= state_nxt;
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = state_r.rdata;
  assign mem_busy_out  = (state_r.st != S_IDLE);
  // core only gets the bus when no channel is waiting or running
  assign cpu_grant_out = cpu_req_in && (state_r.st == S_IDLE) && !gnt_val && !state_r.dhalf;
  assign mem_rd_out    = (state_r.st == S_RD);
  assign mem_wr_out    = (state_r.st == S_WR);
  // address map independent of core memory configuration bits
  assign mem_addr_out  = (state_r.st == S_WR || state_r.st == S_WRW) ?
                         state_r.dst[state_r.ch] : state_r.src[state_r.ch];
  assign mem_wdata_out = state_r.data;
  assign dma_int_out   = state_r.irq;

endmodule

// *** test/sdc_dma_assertions.sv ***
// Port-level timing checks for the six-channel DMA controller
`timescale 1ns/1ps
module sdc_dma_assertions
  import sdc_pkg::*;
#(
  parameter int NUM_EVT = 8
) (
  input wire logic              clk_in,        // Clock
  input wire logic              srst_in,       // Sync reset
  input wire logic              hreadyout_out, // Slave ready
  input wire logic              hresp_out,     // Response
  input wire logic              cpu_req_in,    // Core request
  input wire logic              cpu_grant_out, // Core grant
  input wire logic              mem_busy_out,  // DMA owns bus
  input wire logic              mem_rd_out,    // Read strobe
  input wire logic              mem_wr_out,    // Write strobe
  input wire logic [15:0]       mem_wdata_out, // Write data
  input wire logic [15:0]       mem_rdata_in,  // Read data
  input wire logic [NUM_CH-1:0] dma_int_out    // Interrupts
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  rd_then_wr_a: assert property (mem_rd_out |-> ##2 mem_wr_out)
    else $error("write strobe late");
  busy_five_a: assert property ($rose(mem_busy_out) |-> mem_busy_out[*5] ##1 !mem_busy_out)
    else $error("busy length wrong");
  rd_starts_a: assert property (mem_rd_out |-> $rose(mem_busy_out))
    else $error("read outside transfer start");
  core_blocked_a: assert property (mem_busy_out |-> !cpu_grant_out)
    else $error("core granted during transfer");
  grant_asked_a: assert property (cpu_grant_out |-> cpu_req_in)
    else $error("grant without request");
  wdata_copy_a: assert property (mem_wr_out |-> mem_wdata_out == $past(mem_rdata_in))
    else $error("write data not read data");
  int_after_a: assert property (|dma_int_out |-> $fell(mem_busy_out))
    else $error("interrupt not after transfer");
  int_single_a: assert property (|dma_int_out |=> dma_int_out == '0)
    else $error("interrupt too long");
  bus_okay_a: assert property (hreadyout_out && !hresp_out)
    else $error("bus response not okay");
endmodule

// *** test/sdc_mem_model.sv ***
// Behavioural word memory on the DMA's far side
`timescale 1ns/1ps
module sdc_mem_model (
  input  wire logic        clk_in,   // Clock
  input  wire logic        rd_in,    // Read strobe
  input  wire logic        wr_in,    // Write strobe
  input  wire logic [15:0] addr_in,  // Word address
  input  wire logic [15:0] wdata_in, // Write data
  output logic      [15:0] rdata_out // Data one cycle after strobe
);
  logic [15:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {~i[7:0], i[7:0]} ^ 16'h3c5a;
    end
    rdata_out = 16'h0000;
  end
  // Line toggles outside answers so stale data cannot pass as valid
  always @(posedge clk_in) begin
    rdata_out <= rd_in ? mem[addr_in[7:0]] : ~rdata_out;
    if (wr_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
  end
endmodule

// *** test/tb_sdc_dma.sv ***
// Self-checking bench for the six-channel DMA controller
`timescale 1ns/1ps
module tb_sdc_dma;
  import sdc_pkg::*;
  logic        clk_in = 1'b0, srst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic        cpu_req_in = 1'b0, microcomputer_mode_bit = 1'b0;
  logic        data_rom_map_bit = 1'b0, ram_overlay_bit = 1'b0;
  logic [31:0] haddr_in = '0, hwdata_in = '0, rs_a = 32'd29537, rs_b = 32'd29537;
  logic [1:0]  htrans_in = '0;
  logic [7:0]  sync_events_in = '0;
  logic        hreadyout_out, hresp_out, cpu_grant_out, mem_busy_out, mem_rd_out, mem_wr_out;
  logic [31:0] hrdata_out;
  logic [15:0] mem_addr_out, mem_wdata_out, mem_rdata_in, rd_q[$], int_q[$];
  logic [5:0]  dma_int_out;
  int          failures = 0, cmp_count = 0, int_cnt[6] = '{default: 0};
  always #50 clk_in = ~clk_in;
  sdc_dma sdc_dma_inst (.clk_in, .srst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in(3'b010), .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out,
    .hrdata_out, .sync_events_in, .cpu_req_in, .cpu_grant_out, .mem_busy_out, .mem_rd_out,
    .mem_wr_out, .mem_addr_out, .mem_wdata_out, .mem_rdata_in, .microcomputer_mode_bit,
    .data_rom_map_bit, .ram_overlay_bit, .dma_int_out);
  sdc_mem_model sdc_mem_model_inst (.clk_in, .rd_in(mem_rd_out), .wr_in(mem_wr_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {~a[7:0], a[7:0]} ^ 16'h3c5a;
  endfunction
  function automatic logic [15:0] adj(input logic [15:0] a, input logic [1:0] m,
                                      input logic [15:0] ix);
    return m == 2'b00 ? a : m == 2'b01 ? a + 16'h1 : m == 2'b10 ? a - 16'h1 : a + ix;
  endfunction
  function automatic logic [11:0] ra(input int ch, input logic [5:0] off);
    return CH_STRIDE * ch[11:0] + {6'h00, off};
  endfunction
  // Core request and the ignored core configuration bits toggle at random
  always @(posedge clk_in) begin
    rs_a <= xs(rs_a);
    {cpu_req_in, microcomputer_mode_bit, data_rom_map_bit, ram_overlay_bit} <= rs_a[3:0];
  end
  // Outputs are watched mid-cycle, away from the edge that launches them
  always @(negedge clk_in) begin
    if (mem_rd_out) rd_q.push_back(mem_addr_out);
    if (dma_int_out[4]) int_q.push_back(mem_addr_out);
    for (int c = 0; c < 6; c++) if (dma_int_out[c]) int_cnt[c]++;
  end
  task automatic summarize;
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      summarize;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel_in <= 1'b1;
    haddr_in <= {20'h0, a};
    hwrite_in <= w;
    htrans_in <= 2'b10;
    hold;
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    hold;
    q = hrdata_out;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask
  task automatic wait_int(input int ch, input int target);
    int n;
    n = 0;
    while (int_cnt[ch] < target && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    check("interrupt wait", n < 500, 1'b1);
    if (n >= 500) summarize;
  endtask
  task automatic evp(input logic [7:0] e);
    sync_events_in <= e;
    @(posedge clk_in);
    sync_events_in <= 8'h00;
    repeat (12) @(posedge clk_in);
  endtask
  initial begin
    logic [15:0] s, d, ls, ld, ei, fi;
    logic [1:0]  sm, dm;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rdc("unmapped", 12'h1fc, 32'h0);
    rdc("ecnt reset", ra(0, OFF_ECNT), 32'h0);
    rs_b = xs(rs_b);
    ei = {12'h0, rs_b[3:0]};
    fi = {12'h0, rs_b[7:4]};
    wr(ADR_EIDXA, ei);
    wr(ADR_FIDXA, fi);
    wr(ADR_EIDXB, fi);
    wr(ADR_FIDXB, ei);
    for (int m = 0; m < 4; m++) begin
      rs_b = xs(rs_b);
      s = 16'h0010 + rs_b[3:0];
      d = 16'h0080 + rs_b[7:4];
      sm = m[1:0];
      dm = sm + 2'b01;
      wr(ra(0, OFF_SRC), s);
      wr(ra(0, OFF_DST), d);
      wr(ra(0, OFF_ECNT), 32'h2);
      for (int i = 0; i < 3; i++) begin
        ls = s;
        ld = d;
        s = adj(s, sm, i == 2 ? fi : ei);
        d = adj(d, dm, i == 2 ? ei : fi);
      end
      wr(ra(0, OFF_MODE), {20'h0, 1'b1, dm, 1'b0, sm, 6'h01});
      repeat (30) @(posedge clk_in);
      rdc("enable after block", ra(0, OFF_MODE), {20'h0, 1'b1, dm, 1'b0, sm, 6'h00});
      rdc("source address", ra(0, OFF_SRC), s);
      rdc("destination address", ra(0, OFF_DST), d);
      check("moved word", sdc_mem_model_inst.mem[ld[7:0]], pat(ls));
    end
    check("masked interrupt", int_cnt[0], 0);
    wr(ADR_GSRC, 32'h20);
    wr(ADR_GDST, 32'ha0);
    wr(ADR_GECNT, 32'h1);
    wr(ra(1, OFF_SRC), 32'h30);
    wr(ra(1, OFF_DST), 32'hb0);
    rd_q.delete();
    wr(ra(1, OFF_MODE), 32'h6015);
    repeat (20) @(posedge clk_in);
    check("read without event", rd_q.size(), 0);
    evp(8'h04);
    wait_int(1, 1);
    rdc("reload source", ra(1, OFF_SRC), 32'h20);
    rdc("reload count", ra(1, OFF_ECNT), 32'h1);
    wr(ADR_GSRC, 32'h28);
    rdc("running source", ra(1, OFF_SRC), 32'h20);
    evp(8'h04);
    evp(8'h04);
    wait_int(1, 2);
    rdc("second reload", ra(1, OFF_SRC), 32'h28);
    rdc("kept destination", ra(1, OFF_DST), 32'ha0);
    wr(ra(1, OFF_MODE), 32'h0);
    wr(ra(2, OFF_SRC), 32'h40);
    wr(ra(3, OFF_SRC), 32'h48);
    wr(ra(2, OFF_MODE), 32'h2d);
    wr(ra(3, OFF_MODE), 32'h2f);
    rd_q.delete();
    evp(8'h20);
    repeat (10) @(posedge clk_in);
    check("high first", rd_q[0], 16'h0048);
    check("low next", rd_q[1], 16'h0040);
    rdc("status", ADR_STAT, 32'h200);
    // Double words, two frames, per-channel reload, frame and half interrupts
    wr(ADR_CFG, 32'h1);
    wr(ra(4, OFF_SRC), 32'h50);
    wr(ra(4, OFF_DST), 32'hc0);
    wr(ra(4, OFF_ECNT), 32'h3);
    wr(ra(4, OFF_FCNT), 32'h1);
    wr(ra(4, OFF_RSRC), 32'h60);
    wr(ra(4, OFF_RDST), 32'hd0);
    wr(ra(4, OFF_RECNT), 32'h3);
    wr(ra(4, OFF_MODE), 32'hf241);
    wait_int(4, 3);
    rdc("own reload source", ra(4, OFF_SRC), 32'h60);
    wr(ra(4, OFF_MODE), 32'h0);
    check("frame end point", int_q[0], 16'h0058);
    check("half block point", int_q[1], 16'h005c);
    check("block end point", int_q[2], 16'h0060);
    check("double word data", sdc_mem_model_inst.mem[8'hcf], pat(16'h005f));
    summarize;
  end
endmodule
bind sdc_dma sdc_dma_assertions #(.NUM_EVT(NUM_EVT)) sdc_dma_assertions_inst (.clk_in,
  .srst_in, .hreadyout_out, .hresp_out, .cpu_req_in, .cpu_grant_out, .mem_busy_out,
  .mem_rd_out, .mem_wr_out, .mem_wdata_out, .mem_rdata_in, .dma_int_out);
